// file: hw/mbf_framer.sv
/*
  Serial slave request framer: byte fifo and top module.
  Assumes a byte-level serial receiver that flags each byte and
  the end-of-frame silence, a byte transmitter with ready, and an
  APB master through which the fieldbus controller reaches the buffers.
*/
// Function
// - accept a request only if its first byte equals the set slave address
// - forward request body without address byte and trailing crc
// - optional counter byte and count byte lead the forwarded body
// - counter mode: bump counter byte once per request accepted while idle
// - count byte holds number of received body bytes
// - answer goes out with slave address first and crc appended
// - after sending the answer, wait for the next request
// - change mode: send only when outgoing data differs from last sent
// - counter mode: send only when fieldbus counter byte has changed
// - counter byte is the first byte of both buffers
// - count byte enabled: send that many body bytes, capped at the buffer room after the header bytes
// - buffer length is a fixed parameter; longer request bodies are cut to fit and set the overrun flag
`timescale 1ns/1ns

module mbf_fifo #(
  parameter int W = 8,
  parameter int D = mbf_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // fill side
  input  wire logic         in_valid_in,
  input  wire logic [W-1:0] in_data_in,
  output logic              in_ready_out,
  // drain side
  output logic              out_valid_out,
  output logic [W-1:0]      out_data_out,
  input  wire logic         out_ready_in
);
  localparam int AW = $clog2(D);

  if (D < 2 || (D & (D - 1)) != 0) begin : g_chk
    $error("fifo depth must be a power of two");
  end

  logic [D-1:0][W-1:0] mem_ff;
  logic [AW-1:0]       wp_ff;
  logic [AW-1:0]       rp_ff;
  logic [AW:0]         cnt_ff;
  logic                wr;
  logic                rd;

  assign in_ready_out  = (cnt_ff != (AW+1)'(D));
  assign out_valid_out = (cnt_ff != '0);
  assign out_data_out  = mem_ff[rp_ff];
  assign wr            = in_valid_in & in_ready_out;
  assign rd            = out_valid_out & out_ready_in;

  always_ff @(posedge clk_in) begin
    if (wr) begin
      mem_ff[wp_ff] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff  <= wp_ff + AW'(wr);
      rp_ff  <= rp_ff + AW'(rd);
      cnt_ff <= cnt_ff + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end
endmodule

module mbf_framer #(
  parameter int BUF_LEN = mbf_pkg::BUF_LEN_DEF
) (
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        sys_rst_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // serial receive bytes
  input  wire logic        rx_valid_in,
  input  wire logic [7:0]  rx_data_in,
  input  wire logic        rx_end_in,
  // serial transmit bytes
  output logic             tx_valid_out,
  output logic [7:0]       tx_data_out,
  input  wire logic        tx_ready_in
);
  import mbf_pkg::*;

  if (BUF_LEN < 4 || BUF_LEN > 64) begin : g_chk
    $error("buffer length must be 4 to 64");
  end

  typedef logic [BUF_LEN-1:0][7:0] mbf_buf_t;

  // ****************************************
  // state
  // ****************************************
  mbf_ctrl_t  ctrl_ff;
  mbf_state_t st_ff;
  mbf_state_t nxt_st;
  mbf_buf_t   in_buf_ff;
  mbf_buf_t   nxt_in_buf;
  mbf_buf_t   out_buf_ff;
  mbf_buf_t   shd_ff;
  mbf_buf_t   stg_ff;
  logic [CW-1:0] rx_cnt_ff;
  logic [CW-1:0] idx_ff;
  logic [CW-1:0] snd_len_ff;
  logic [15:0]   rx_crc_ff;
  logic [15:0]   tx_crc_ff;
  logic          addr_ok_ff;
  logic          ovr_ff;
  logic [31:0]   prdata_ff;
  logic          pready_ff;
  logic          pslverr_ff;
  logic          tx_valid_ff;
  logic [7:0]    tx_data_ff;

  // ****************************************
  // apb decode
  // ****************************************
  wire           acc      = psel_in & penable_in & pready_ff;
  wire [5:0]     ridx     = paddr_in[7:2];
  wire           in_rng   = (int'(ridx) < BUF_LEN) && (paddr_in[1:0] == 2'h0);
  wire           sel_ctrl = (paddr_in == ADR_CTRL);
  wire           sel_stat = (paddr_in == ADR_STAT);
  wire           sel_in   = (paddr_in[11:8] == PAGE_IN) && in_rng;
  wire           sel_out  = (paddr_in[11:8] == PAGE_OUT) && in_rng;
  wire           bad      = !(sel_ctrl | sel_stat | sel_in | sel_out) | (pwrite_in & sel_in);
  wire           wr_ctrl  = acc & pwrite_in & sel_ctrl;
  wire           wr_stat  = acc & pwrite_in & sel_stat;
  wire           wr_out   = acc & pwrite_in & sel_out;
  wire [31:0]    rd_mux   = sel_ctrl ? {16'h0000, ctrl_ff.slave_address_setting, 6'h00,
                                        ctrl_ff.len_en, ctrl_ff.trig_en} :
                            sel_stat ? {28'h0000000, ovr_ff, st_ff} :
                            sel_in   ? {24'h000000, in_buf_ff[ridx]} :
                            sel_out  ? {24'h000000, out_buf_ff[ridx]} : 32'h00000000;

  // ****************************************
  // frame layout
  // ****************************************
  wire [1:0]     hdr      = {1'b0, ctrl_ff.trig_en} + {1'b0, ctrl_ff.len_en};
  wire [CW-1:0]  room     = CW'(BUF_LEN) - CW'(hdr);
  wire           len_pos  = ctrl_ff.trig_en;
  wire [CW-1:0]  body     = rx_cnt_ff - MIN_FRAME + 9'h001;
  wire           frame_ok = addr_ok_ff && (rx_crc_ff == CRC_RESIDUE) && (rx_cnt_ff >= MIN_FRAME);
  wire           commit   = rx_end_in & frame_ok & (st_ff == ST_IDLE);
  wire           ovr_set  = commit & (body > room);
  wire [CW-1:0]  stg_pos  = rx_cnt_ff - 9'h001;
  wire           rx_take  = rx_valid_in & ~rx_end_in;

  // ****************************************
  // answer selection
  // ****************************************
  wire           chg      = ctrl_ff.trig_en ? (out_buf_ff[0] != shd_ff[0]) : (out_buf_ff != shd_ff);
  wire           start    = (st_ff == ST_WAIT) & chg;
  wire [CW-1:0]  req_len  = {1'b0, out_buf_ff[len_pos]};
  wire [CW-1:0]  snd_len  = !ctrl_ff.len_en ? room : (req_len < room ? req_len : room);
  wire [CW-1:0]  bpos     = CW'(hdr) + idx_ff - 9'h001;
  wire [7:0]     body_b   = shd_ff[bpos[5:0]];
  wire [7:0]     push_d   = (idx_ff == '0)                   ? ctrl_ff.slave_address_setting :
                            (idx_ff <= snd_len_ff)          ? body_b :
                            (idx_ff == snd_len_ff + 9'h001) ? tx_crc_ff[7:0] : tx_crc_ff[15:8];
  wire           push_v   = (st_ff == ST_SEND);
  wire           f_ready;
  wire           push_f   = push_v & f_ready;
  wire           last     = (idx_ff == snd_len_ff + CRC_BYTES);
  wire           done     = push_f & last;
  wire           f_valid;
  wire [7:0]     f_data;
  wire           drain    = f_valid & (~tx_valid_ff | tx_ready_in);

  // ****************************************
  // forwarded buffer image
  // ****************************************
  always_comb begin
    for (int i = 0; i < BUF_LEN; i++) begin
      nxt_in_buf[i] = 8'h00;
      if (i >= int'(hdr) && (i - int'(hdr)) < int'(body)) begin
        nxt_in_buf[i] = stg_ff[i - int'(hdr)];
      end
    end
    if (ctrl_ff.len_en) begin
      nxt_in_buf[len_pos] = (body > 9'h0FF) ? 8'hFF : body[7:0];
    end
    if (ctrl_ff.trig_en) begin
      nxt_in_buf[0] = in_buf_ff[0] + 8'h01;
    end
  end

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE: begin
        if (commit) begin
          nxt_st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (start) begin
          nxt_st = ST_SEND;
        end
      end
      ST_SEND: begin
        if (done) begin
          nxt_st = ST_IDLE;
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end else begin
      pready_ff  <= psel_in & penable_in & ~pready_ff;
      pslverr_ff <= psel_in & penable_in & ~pready_ff & bad;
      prdata_ff  <= (psel_in & ~pwrite_in) ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      ctrl_ff    <= '{slave_address_setting: ADDR_RST, len_en: 1'b0, trig_en: 1'b0};
      out_buf_ff <= '0;
      ovr_ff     <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= '{slave_address_setting: pwdata_in[15:8], len_en: pwdata_in[1], trig_en: pwdata_in[0]};
      end
      if (wr_out) begin
        out_buf_ff[ridx] <= pwdata_in[7:0];
      end
      ovr_ff <= ovr_set | (ovr_ff & ~(wr_stat & pwdata_in[3]));
    end
  end

  // receive side: count, check address and crc, stage body
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rx_cnt_ff  <= '0;
      rx_crc_ff  <= CRC_INIT;
      addr_ok_ff <= 1'b0;
      stg_ff     <= '0;
      in_buf_ff  <= '0;
    end else begin
      if (rx_end_in) begin
        rx_cnt_ff <= '0;
        rx_crc_ff <= CRC_INIT;
      end else if (rx_take) begin
        rx_cnt_ff <= (rx_cnt_ff == '1) ? rx_cnt_ff : rx_cnt_ff + 9'h001;
        rx_crc_ff <= mbf_crc_step(rx_crc_ff, rx_data_in);
        if (rx_cnt_ff == '0) begin
          addr_ok_ff <= (rx_data_in == ctrl_ff.slave_address_setting);
        end else if (int'(stg_pos) < BUF_LEN) begin
          stg_ff[stg_pos[5:0]] <= rx_data_in;
        end
      end
      if (commit) begin
        in_buf_ff <= nxt_in_buf;
      end
    end
  end

  // transmit side: snapshot answer, push address, body, crc
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      st_ff      <= ST_IDLE;
      shd_ff     <= '0;
      idx_ff     <= '0;
      snd_len_ff <= '0;
      tx_crc_ff  <= CRC_INIT;
    end else begin
      st_ff <= nxt_st;
      if (start) begin
        shd_ff     <= out_buf_ff;
        snd_len_ff <= snd_len;
        idx_ff     <= '0;
        tx_crc_ff  <= CRC_INIT;
      end else if (push_f) begin
        idx_ff <= idx_ff + 9'h001;
        if (idx_ff <= snd_len_ff) begin
          tx_crc_ff <= mbf_crc_step(tx_crc_ff, push_d);
        end
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      tx_valid_ff <= 1'b0;
      tx_data_ff  <= 8'h00;
    end else if (drain) begin
      tx_valid_ff <= 1'b1;
      tx_data_ff  <= f_data;
    end else if (tx_ready_in) begin
      tx_valid_ff <= 1'b0;
    end
  end

  mbf_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .clk_in        (mclk_in),
    .rst_in        (sys_rst_in),
    .in_valid_in   (push_v),
    .in_data_in    (push_d),
    .in_ready_out  (f_ready),
    .out_valid_out (f_valid),
    .out_data_out  (f_data),
    .out_ready_in  (drain)
  );

  assign prdata_out   = prdata_ff;
  assign pready_out   = pready_ff;
  assign pslverr_out  = pslverr_ff;
  assign tx_valid_out = tx_valid_ff;
  assign tx_data_out  = tx_data_ff;

  // ****************************************
  // checks
  // ****************************************
  property p_addr;
    @(posedge mclk_in) disable iff (sys_rst_in) commit |-> addr_ok_ff && rx_cnt_ff >= MIN_FRAME;
  endproperty
  a_addr: assert property (p_addr) else $error("request taken with wrong address");

  property p_crc;
    @(posedge mclk_in) disable iff (sys_rst_in) commit |-> rx_crc_ff == CRC_RESIDUE;
  endproperty
  a_crc: assert property (p_crc) else $error("request taken with bad crc");

  property p_drop;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (rx_end_in && !frame_ok && st_ff == ST_IDLE) |=> st_ff == ST_IDLE && $stable(in_buf_ff);
  endproperty
  a_drop: assert property (p_drop) else $error("bad frame changed state");

  property p_count;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (commit && ctrl_ff.len_en && body < 9'h0FF) |=> in_buf_ff[len_pos] == $past(body[7:0]);
  endproperty
  a_count: assert property (p_count) else $error("count byte wrong");

  property p_trig;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (commit && ctrl_ff.trig_en) |=> in_buf_ff[0] == $past(in_buf_ff[0]) + 8'h01;
  endproperty
  a_trig: assert property (p_trig) else $error("counter byte not bumped");

  property p_start;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (st_ff == ST_WAIT && !chg) |=> st_ff != ST_SEND;
  endproperty
  a_start: assert property (p_start) else $error("answer sent without change");

  property p_first;
    @(posedge mclk_in) disable iff (sys_rst_in)
      start |=> push_v && push_d == ctrl_ff.slave_address_setting;
  endproperty
  a_first: assert property (p_first) else $error("answer does not open with address");

  property p_end;
    @(posedge mclk_in) disable iff (sys_rst_in)
      done |=> st_ff == ST_IDLE ##1 st_ff != ST_SEND;
  endproperty
  a_end: assert property (p_end) else $error("no return to idle after answer");

  property p_len;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (push_v && ctrl_ff.len_en) |-> snd_len_ff <= room && idx_ff <= snd_len_ff + CRC_BYTES;
  endproperty
  a_len: assert property (p_len) else $error("answer length overrun");
endmodule

// file: hw/mbf_pkg.sv
/*
  Shared constants and types of the serial request framer.
  Assumes one system clock and a synchronous active-high reset.
*/
package mbf_pkg;

  // ****************************************
  // sizes and register map
  // ****************************************
  localparam int          BUF_LEN_DEF = 32;
  localparam int          FIFO_DEPTH  = 16;
  localparam int          CW          = 9;
  localparam logic [11:0] ADR_CTRL    = 12'h000;
  localparam logic [11:0] ADR_STAT    = 12'h004;
  localparam logic [3:0]  PAGE_IN     = 4'h1;
  localparam logic [3:0]  PAGE_OUT    = 4'h2;

  // ****************************************
  // reset values and frame constants
  // ****************************************
  localparam logic [7:0]  ADDR_RST    = 8'h01;
  localparam logic [15:0] CRC_INIT    = 16'hFFFF;
  localparam logic [15:0] CRC_POLY    = 16'hA001;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;
  localparam logic [8:0]  MIN_FRAME   = 9'h004;
  localparam logic [8:0]  CRC_BYTES   = 9'h002;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [7:0] slave_address_setting;
    logic       len_en;
    logic       trig_en;
  } mbf_ctrl_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_SEND = 3'b100
  } mbf_state_t;

  // one byte of the reflected crc, lsb first
  function automatic logic [15:0] mbf_crc_step(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int b = 0; b < 8; b++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

endpackage

// file: verification/mbf_framer_tb_top.sv
/*
  Self-checking bench of the serial request framer.
  Assumes the package, the framer and the serial master model compiled first.
*/
`timescale 1ns/1ns

module mbf_framer_tb_top;
  import mbf_pkg::*;

  localparam int BL = 8;
  logic        mclk_in    = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        psel       = 1'b0;
  logic        pen        = 1'b0;
  logic        pwr        = 1'b0;
  logic [11:0] padr       = 12'h000;
  logic [31:0] pwd        = 32'h0;
  logic [31:0] prd;
  logic        prdy, perr, rxv, rxe, txv, txr;
  logic [7:0]  rxd, txd;
  logic        slow       = 1'b0;
  int          seed       = 22;
  int          miscompares = 0;
  int          checks_done = 0;
  logic [7:0]  q[$], a[$], om[BL];

  always #50 mclk_in = ~mclk_in;

  mbf_framer #(.BUF_LEN(BL)) i_dut (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(padr), .pwdata_in(pwd),
    .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr),
    .rx_valid_in(rxv), .rx_data_in(rxd), .rx_end_in(rxe),
    .tx_valid_out(txv), .tx_data_out(txd), .tx_ready_in(txr)
  );

  mbf_serial_master i_master (
    .mclk_in(mclk_in), .slow_in(slow), .rx_valid_out(rxv), .rx_data_out(rxd), .rx_end_out(rxe),
    .tx_valid_in(txv), .tx_data_in(txd), .tx_ready_out(txr)
  );

  // ****
  // expectations
  // ****
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c = 16'hFFFF;
    foreach (b[i]) begin
      c ^= {8'h00, b[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction

  function automatic logic [31:0] in_byte(input int i, input int h, input logic [7:0] k, input logic [7:0] b[$]);
    if (h == 2 && i == 0) return {24'h0, k};
    if (h == 2 && i == 1) return 32'(b.size());
    if (h == 1 && i == 0) return 32'(b.size());
    return (i - h < b.size()) ? {24'h0, b[i-h]} : 32'h0;
  endfunction

  // ****
  // checks and bus tasks
  // ****
  task automatic final_report();
    if (miscompares == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n = 0;
    @(posedge mclk_in);
    psel <= 1'b1;
    pwr  <= w;
    padr <= ad;
    pwd  <= d;
    @(posedge mclk_in);
    pen <= 1'b1;
    do begin
      @(posedge mclk_in);
      n++;
    end while (prdy !== 1'b1 && n < 20);
    r = prd;
    e = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      final_report();
    end
  endtask

  task automatic rd(input logic [11:0] ad, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, ad, 32'h0, r, e);
    chk({31'h0, e}, {31'h0, xe});
    if (!xe) chk(r, x);
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] d, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b1, ad, d, r, e);
    chk({31'h0, e}, {31'h0, xe});
  endtask

  task automatic frame(input logic [7:0] ad, input logic [7:0] b[$], input logic good);
    logic [15:0] c;
    b.push_front(ad);
    c = crc16(b);
    b.push_back(c[7:0] ^ {7'h0, !good});
    b.push_back(c[15:8]);
    i_master.send(b);
  endtask

  task automatic expect_tx(input logic [7:0] b[$]);
    logic [15:0] c;
    int          n = 0;
    c = crc16(b);
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    while (i_master.got.size() < b.size() && n < 600) begin
      @(posedge mclk_in);
      n++;
    end
    if (n >= 600) begin
      miscompares++;
      final_report();
    end
    rd(ADR_STAT, 32'h1, 1'b0);
    chk(i_master.got.size(), b.size());
    foreach (b[i]) chk(i_master.got[i], b[i]);
    i_master.got.delete();
  endtask

  // ****
  // main sequence
  // ****
  initial begin
    repeat (50000) @(posedge mclk_in);
    miscompares++;
    final_report();
  end

  initial begin
    int m;
    repeat (2) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    rd(ADR_CTRL, 32'h100, 1'b0);
    rd(ADR_STAT, 32'h1, 1'b0);
    rd(12'h008, 32'h0, 1'b1);
    rd({PAGE_OUT, 8'h20}, 32'h0, 1'b1);
    wr({PAGE_IN, 8'h00}, 32'hFF, 1'b1);
    rd({PAGE_IN, 8'h00}, 32'h0, 1'b0);
    wr(ADR_CTRL, 32'h5A03, 1'b0);
    a = {8'h01, 8'h02};
    frame(8'h5B, a, 1'b1);
    rd(ADR_STAT, 32'h1, 1'b0);
    frame(8'h5A, a, 1'b0);
    rd(ADR_STAT, 32'h1, 1'b0);
    a.delete();
    frame(8'h5A, a, 1'b1);
    rd(ADR_STAT, 32'h1, 1'b0);
    for (int k = 1; k < 3; k++) begin
      q.delete();
      repeat (1 + {$random(seed)} % 6) q.push_back(8'($random(seed)));
      frame(8'h5A, q, 1'b1);
      rd(ADR_STAT, 32'h2, 1'b0);
      for (int i = 0; i < BL; i++) rd({PAGE_IN, 6'(i), 2'b00}, in_byte(i, 2, 8'(k), q), 1'b0);
      frame(8'h5A, q, 1'b1);
      rd({PAGE_IN, 8'h00}, 32'(k), 1'b0);
      m = 1 + {$random(seed)} % 6;
      a = {8'h5A};
      om[1] = 8'(m);
      for (int i = 2; i < BL; i++) begin
        om[i] = 8'($random(seed));
        if (i < m + 2) a.push_back(om[i]);
      end
      for (int i = 1; i < BL; i++) wr({PAGE_OUT, 6'(i), 2'b00}, {24'h0, om[i]}, 1'b0);
      rd(ADR_STAT, 32'h2, 1'b0);
      om[0] = 8'(k);
      wr({PAGE_OUT, 8'h00}, 32'(k), 1'b0);
      expect_tx(a);
    end
    wr(ADR_CTRL, 32'h5A00, 1'b0);
    slow <= 1'b1;
    q.delete();
    repeat (10) q.push_back(8'($random(seed)));
    frame(8'h5A, q, 1'b1);
    rd(ADR_STAT, 32'hA, 1'b0);
    for (int i = 0; i < BL; i++) rd({PAGE_IN, 6'(i), 2'b00}, in_byte(i, 0, 8'h0, q), 1'b0);
    wr(ADR_STAT, 32'h8, 1'b0);
    rd(ADR_STAT, 32'h2, 1'b0);
    wr({PAGE_OUT, 8'h0C}, {24'h0, om[3]}, 1'b0);
    rd(ADR_STAT, 32'h2, 1'b0);
    om[3] = ~om[3];
    wr({PAGE_OUT, 8'h0C}, {24'h0, om[3]}, 1'b0);
    a = {8'h5A};
    foreach (om[i]) a.push_back(om[i]);
    expect_tx(a);
    wr(ADR_CTRL, 32'h5A02, 1'b0);
    q.delete();
    repeat (3) q.push_back(8'($random(seed)));
    frame(8'h5A, q, 1'b1);
    rd(ADR_STAT, 32'h2, 1'b0);
    for (int i = 0; i < BL; i++) rd({PAGE_IN, 6'(i), 2'b00}, in_byte(i, 1, 8'h0, q), 1'b0);
    final_report();
  end
endmodule

// file: verification/mbf_serial_master.sv
/*
  Serial bus master model: sends request bytes and takes answer bytes.
  Assumes one clock shared with the framer; stalls when slow_in is high.
*/
`timescale 1ns/1ns

module mbf_serial_master (
  // clock and stall control
  input  wire logic       mclk_in,
  input  wire logic       slow_in,
  // request bytes toward the framer
  output logic            rx_valid_out,
  output logic [7:0]      rx_data_out,
  output logic            rx_end_out,
  // answer bytes from the framer
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_data_in,
  output logic            tx_ready_out
);
  int         seed = 22;
  logic [7:0] got[$];

  initial begin
    rx_valid_out = 1'b0;
    rx_data_out  = 8'hA5;
    rx_end_out   = 1'b0;
    tx_ready_out = 1'b0;
  end

  // ****
  // one frame, then the end-of-frame pulse
  // ****
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      @(posedge mclk_in);
      rx_valid_out <= 1'b1;
      rx_data_out  <= b[i];
    end
    @(posedge mclk_in);
    rx_valid_out <= 1'b0;
    rx_data_out  <= ~b[b.size()-1];
    rx_end_out   <= 1'b1;
    @(posedge mclk_in);
    rx_end_out   <= 1'b0;
  endtask

  // ****
  // answer side with optional stalls
  // ****
  always @(posedge mclk_in) begin
    tx_ready_out <= !slow_in || ($random(seed) % 3 == 0);
  end

  always @(posedge mclk_in) begin
    if (tx_valid_in === 1'b1 && tx_ready_out === 1'b1) begin
      got.push_back(tx_data_in);
    end
  end
endmodule
